// >>> rtl/sfwp_defs.svh
/*
 Constants of the serial flash write-protection block: register offsets,
 field positions, reset values, opcodes, array sizes and timing counts.
 Assumes a 250 MHz system clock and inclusion by bare name.
*/
`ifndef SFWP_DEFS_SVH
`define SFWP_DEFS_SVH

`define SFWP_REG_STATUS 8'h00
`define SFWP_REG_CONTROL 8'h04
`define SFWP_REG_CONFIG 8'h08
`define SFWP_REG_REFUSED 8'h0c

`define SFWP_RESP_OKAY 2'h0
`define SFWP_RESP_SLVERR 2'h2

`define SFWP_OPC_WRITE_ENABLE 8'h06
`define SFWP_OPC_WRITE_DISABLE 8'h04
`define SFWP_OPC_PAGE_PROGRAM 8'h02
`define SFWP_OPC_SECTOR_ERASE 8'h20
`define SFWP_OPC_BLOCK_ERASE 8'hd8
`define SFWP_OPC_CHIP_ERASE_A 8'hc7
`define SFWP_OPC_CHIP_ERASE_B 8'h60
`define SFWP_OPC_WRITE_STATUS_ONE 8'h01
`define SFWP_OPC_WRITE_STATUS_TWO 8'h31
`define SFWP_OPC_WRITE_STATUS_THREE 8'h11
`define SFWP_OPC_POWER_DOWN 8'hb9
`define SFWP_OPC_RELEASE_POWER_DOWN 8'hab
`define SFWP_OPC_RESET_ENABLE 8'h66
`define SFWP_OPC_RESET 8'h99

// status register one fields
`define SFWP_S1_STATUS_PROTECT 7
`define SFWP_S1_GRANULARITY 6
`define SFWP_S1_TOP_BOTTOM 5
`define SFWP_S1_BP_HI 4
`define SFWP_S1_BP_LO 2
`define SFWP_S1_LATCH 1
`define SFWP_S1_BUSY 0
`define SFWP_S1_WRITE_MASK 8'hfc
// status register two fields
`define SFWP_S2_COMPLEMENT 6
`define SFWP_S2_QUAD 1
`define SFWP_S2_WRITE_MASK 8'h42
// status register three fields
`define SFWP_S3_PIN_SELECT 7
`define SFWP_S3_DRIVE_HI 6
`define SFWP_S3_DRIVE_LO 5
`define SFWP_S3_HIGH_FREQ 4
`define SFWP_S3_WRITE_MASK 8'hf0

`define SFWP_S1_RESET 8'h00
`define SFWP_S2_RESET 8'h00
`define SFWP_S3_RESET 8'h00

`define SFWP_DRIVE_PCT_00 7'h32
`define SFWP_DRIVE_PCT_01 7'h19
`define SFWP_DRIVE_PCT_10 7'h4b
`define SFWP_DRIVE_PCT_11 7'h64

`define SFWP_ARRAY_BYTES 20'h80000
`define SFWP_SIZE_4K 20'h01000
`define SFWP_SIZE_8K 20'h02000
`define SFWP_SIZE_16K 20'h04000
`define SFWP_SIZE_32K 20'h08000
`define SFWP_SIZE_64K 20'h10000
`define SFWP_SIZE_128K 20'h20000
`define SFWP_SIZE_256K 20'h40000
`define SFWP_PAGE_MASK 20'h000ff
`define SFWP_SECTOR_MASK 20'h00fff
`define SFWP_BLOCK_MASK 20'h0ffff
`define SFWP_ARRAY_MASK 20'h7ffff

`define SFWP_CLK_PERIOD_NS 4
`define SFWP_PUW_TIME_US 10
`define SFWP_PUW_CYCLES ((`SFWP_PUW_TIME_US * 1000) / `SFWP_CLK_PERIOD_NS)
`define SFWP_OP_TIME_NS 400
`define SFWP_OP_CYCLES (`SFWP_OP_TIME_NS / `SFWP_CLK_PERIOD_NS)

`endif

// >>> rtl/sfwp_pkg.sv
/*
 Types of the serial flash write-protection block.
 Assumes the constants header is compiled alongside.
*/
package sfwp_pkg;

   typedef enum logic [1:0] {
      SFWP_PWR_OFF,
      SFWP_PWR_LOCKED,
      SFWP_PWR_READY
   } sfwp_power_type;

   typedef enum logic [2:0] {
      SFWP_SEL_STATUS,
      SFWP_SEL_CONTROL,
      SFWP_SEL_CONFIG,
      SFWP_SEL_REFUSED,
      SFWP_SEL_NONE
   } sfwp_reg_sel_type;

   typedef struct packed {
      logic [4:0] stage1;
      logic [4:0] stage2;
   } sfwp_sync_state_type;

   typedef struct packed {
      logic sclk_prev;
      logic cs_prev;
      logic [7:0] shift;
      logic [2:0] bit_cnt;
      logic [2:0] byte_cnt;
      logic [3:0][7:0] bytes;
      sfwp_power_type power;
      logic [15:0] puw_cnt;
      logic [15:0] busy_cnt;
      logic busy;
      logic write_enable_latch;
      logic deep_power_down;
      logic reset_armed;
      logic lock_down;
      logic [7:0] status_reg_one;
      logic [7:0] status_reg_two;
      logic [7:0] status_reg_three;
      logic hold_func_en;
      logic reset_func_en;
      logic io3_data_mode;
      logic [6:0] drive_pct;
      logic quad_hf_mode;
      logic prog_start;
      logic erase_start;
      logic status_write;
      logic [18:0] op_addr;
      logic cmd_refused;
      logic [7:0] refused_cnt;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sfwp_state_type;

endpackage

// >>> rtl/sfwp_sync.sv
/*
 Two-flop synchroniser for the asynchronous pins of the protection block.
 Assumes inputs may change at any time relative to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sfwp_sync
   import sfwp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [4:0] async_in,
   output logic [4:0] sync_out
);
   sfwp_sync_state_type q;
   sfwp_sync_state_type d;

   always_comb begin
      d = q;
      d.stage1 = async_in;
      d.stage2 = q.stage1;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.stage2;
endmodule
`default_nettype wire

// >>> rtl/sfwp_top.sv
/*
 Write-protection and pin-configuration logic of a serial flash: decodes
 commands from the serial link, keeps the write-enable latch, the power-up
 lockout and the protection map, and exposes state over AXI4-Lite.
 Assumes the link clock is far slower than sys_clk (several cycles a phase)
 and that AXI masters follow the usual valid/ready rules.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfwp_defs.svh"
module sfwp_top
   import sfwp_pkg::*;
#(
   parameter logic [15:0] PUW_CYCLES = 16'(`SFWP_PUW_CYCLES),
   parameter logic [15:0] OP_CYCLES = 16'(`SFWP_OP_CYCLES)
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic supply_good,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   input wire logic wp_n,
   output logic hold_func_en,
   output logic reset_func_en,
   output logic io3_data_mode,
   output logic [6:0] drive_pct,
   output logic quad_hf_mode,
   output logic prog_start,
   output logic erase_start,
   output logic status_write,
   output logic [18:0] op_addr,
   output logic cmd_refused,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   sfwp_state_type q;
   sfwp_state_type d;
   logic [4:0] pins;
   logic s_sclk, s_cs_n, s_mosi, s_wp_n, s_supply;

   sfwp_sync u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in({supply_good, wp_n, spi_mosi, spi_cs_n, spi_sclk}),
      .sync_out(pins)
   );
   assign {s_supply, s_wp_n, s_mosi, s_cs_n, s_sclk} = pins;

   function automatic sfwp_reg_sel_type decode(input logic [7:0] addr);
      case (addr)
         `SFWP_REG_STATUS: decode = SFWP_SEL_STATUS;
         `SFWP_REG_CONTROL: decode = SFWP_SEL_CONTROL;
         `SFWP_REG_CONFIG: decode = SFWP_SEL_CONFIG;
         `SFWP_REG_REFUSED: decode = SFWP_SEL_REFUSED;
         default: decode = SFWP_SEL_NONE;
      endcase
   endfunction

   // size of the region counted from address zero before any inversion
   function automatic logic [19:0] prot_size(input logic gran,
      input logic topbot, input logic [2:0] bp);
      if (bp == 3'h0) begin
         prot_size = 20'h0;
      end else if (bp[2:1] == 2'h3 || (!gran && bp == 3'h5)) begin
         prot_size = `SFWP_ARRAY_BYTES;
      end else if (!topbot) begin
         prot_size = 20'h0;
      end else if (!gran) begin
         case (bp)
            3'h1: prot_size = `SFWP_SIZE_64K;
            3'h2: prot_size = `SFWP_SIZE_128K;
            3'h3: prot_size = `SFWP_SIZE_256K;
            default: prot_size = `SFWP_ARRAY_BYTES;
         endcase
      end else begin
         case (bp)
            3'h1: prot_size = `SFWP_SIZE_4K;
            3'h2: prot_size = `SFWP_SIZE_8K;
            3'h3: prot_size = `SFWP_SIZE_16K;
            default: prot_size = `SFWP_SIZE_32K;
         endcase
      end
   endfunction

   // any byte of [lo,hi] protected; complement turns the region round
   function automatic logic region_hit(input logic [19:0] lo,
      input logic [19:0] hi, input logic [19:0] size, input logic compl);
      if (compl) begin
         region_hit = (hi >= size);
      end else begin
         region_hit = (lo < size);
      end
   endfunction

   logic sclk_rise, cs_rise, cs_fall;
   logic [7:0] opc;
   logic [19:0] a_lo, a_hi, mask, psize;
   logic write_class, status_locked, hit;

   always_comb begin
      d = q;
      d.prog_start = 1'b0;
      d.erase_start = 1'b0;
      d.status_write = 1'b0;
      d.cmd_refused = 1'b0;
      sclk_rise = s_sclk && !q.sclk_prev;
      cs_rise = s_cs_n && !q.cs_prev;
      cs_fall = !s_cs_n && q.cs_prev;
      d.sclk_prev = s_sclk;
      d.cs_prev = s_cs_n;
      opc = q.bytes[0];
      case (opc)
         `SFWP_OPC_PAGE_PROGRAM: mask = `SFWP_PAGE_MASK;
         `SFWP_OPC_SECTOR_ERASE: mask = `SFWP_SECTOR_MASK;
         `SFWP_OPC_BLOCK_ERASE: mask = `SFWP_BLOCK_MASK;
         default: mask = `SFWP_ARRAY_MASK;
      endcase
      a_lo = {1'b0, q.bytes[1][2:0], q.bytes[2], q.bytes[3]} & ~mask;
      a_hi = a_lo | mask;
      psize = prot_size(q.status_reg_one[`SFWP_S1_GRANULARITY],
         q.status_reg_one[`SFWP_S1_TOP_BOTTOM],
         q.status_reg_one[`SFWP_S1_BP_HI:`SFWP_S1_BP_LO]);
      hit = region_hit(a_lo, a_hi, psize,
         q.status_reg_two[`SFWP_S2_COMPLEMENT]);
      // write-protect pin loses its meaning once quad I/O owns it
      status_locked = q.lock_down ||
         (q.status_reg_one[`SFWP_S1_STATUS_PROTECT] && !s_wp_n &&
          !q.status_reg_two[`SFWP_S2_QUAD]);
      write_class = (opc == `SFWP_OPC_PAGE_PROGRAM) ||
         (opc == `SFWP_OPC_SECTOR_ERASE) || (opc == `SFWP_OPC_BLOCK_ERASE) ||
         (opc == `SFWP_OPC_CHIP_ERASE_A) || (opc == `SFWP_OPC_CHIP_ERASE_B);

      case (q.power)
         SFWP_PWR_OFF: begin
            if (s_supply) begin
               d.power = SFWP_PWR_LOCKED;
               d.puw_cnt = 16'h0;
            end
         end
         SFWP_PWR_LOCKED: begin
            d.puw_cnt = q.puw_cnt + 16'h1;
            if (q.puw_cnt >= PUW_CYCLES - 16'h1) begin
               d.power = SFWP_PWR_READY;
            end
         end
         default: d.power = SFWP_PWR_READY;
      endcase

      if (q.busy) begin
         d.busy_cnt = q.busy_cnt + 16'h1;
         if (q.busy_cnt >= OP_CYCLES - 16'h1) begin
            d.busy = 1'b0;
            d.write_enable_latch = 1'b0;
         end
      end

      if (cs_fall) begin
         d.bit_cnt = 3'h0;
         d.byte_cnt = 3'h0;
      end else if (!s_cs_n && sclk_rise) begin
         d.shift = {q.shift[6:0], s_mosi};
         d.bit_cnt = q.bit_cnt + 3'h1;
         if (q.bit_cnt == 3'h7) begin
            if (q.byte_cnt < 3'h4) begin
               d.bytes[q.byte_cnt[1:0]] = {q.shift[6:0], s_mosi};
            end
            if (q.byte_cnt != 3'h7) begin
               d.byte_cnt = q.byte_cnt + 3'h1;
            end
         end
      end

      // a frame ends at chip select rise; partial bytes void it
      if (cs_rise && q.power != SFWP_PWR_OFF && q.byte_cnt != 3'h0) begin
         if (q.bit_cnt != 3'h0) begin
            // dormant or busy devices drop cut frames without a pulse
            d.cmd_refused = write_class &&
               !q.deep_power_down && !q.busy;
         end else if (q.deep_power_down) begin
            if (opc == `SFWP_OPC_RELEASE_POWER_DOWN) begin
               d.deep_power_down = 1'b0;
            end
         end else if (!q.busy) begin
            d.reset_armed = 1'b0;
            case (opc)
               `SFWP_OPC_WRITE_ENABLE: begin
                  if (q.power == SFWP_PWR_READY) begin
                     d.write_enable_latch = 1'b1;
                  end else begin
                     d.cmd_refused = 1'b1;
                  end
               end
               `SFWP_OPC_WRITE_DISABLE: d.write_enable_latch = 1'b0;
               `SFWP_OPC_PAGE_PROGRAM, `SFWP_OPC_SECTOR_ERASE,
               `SFWP_OPC_BLOCK_ERASE, `SFWP_OPC_CHIP_ERASE_A,
               `SFWP_OPC_CHIP_ERASE_B: begin
                  if (q.power != SFWP_PWR_READY ||
                      !q.write_enable_latch || hit ||
                      (mask != `SFWP_ARRAY_MASK && q.byte_cnt < 3'h4)) begin
                     d.cmd_refused = 1'b1;
                  end else begin
                     d.busy = 1'b1;
                     d.busy_cnt = 16'h0;
                     d.op_addr = a_lo[18:0];
                     d.prog_start = (opc == `SFWP_OPC_PAGE_PROGRAM);
                     d.erase_start = (opc != `SFWP_OPC_PAGE_PROGRAM);
                  end
               end
               `SFWP_OPC_WRITE_STATUS_ONE, `SFWP_OPC_WRITE_STATUS_TWO,
               `SFWP_OPC_WRITE_STATUS_THREE: begin
                  if (q.power != SFWP_PWR_READY || !q.write_enable_latch ||
                      status_locked || q.byte_cnt < 3'h2) begin
                     d.cmd_refused = 1'b1;
                  end else begin
                     d.busy = 1'b1;
                     d.busy_cnt = 16'h0;
                     d.status_write = 1'b1;
                     if (opc == `SFWP_OPC_WRITE_STATUS_ONE) begin
                        d.status_reg_one = q.bytes[1] & `SFWP_S1_WRITE_MASK;
                        if (q.byte_cnt >= 3'h3) begin
                           d.status_reg_two = q.bytes[2] & `SFWP_S2_WRITE_MASK;
                        end
                     end else if (opc == `SFWP_OPC_WRITE_STATUS_TWO) begin
                        d.status_reg_two = q.bytes[1] & `SFWP_S2_WRITE_MASK;
                     end else begin
                        d.status_reg_three = q.bytes[1] & `SFWP_S3_WRITE_MASK;
                     end
                  end
               end
               `SFWP_OPC_POWER_DOWN: d.deep_power_down = 1'b1;
               `SFWP_OPC_RESET_ENABLE: d.reset_armed = 1'b1;
               `SFWP_OPC_RESET: begin
                  if (q.reset_armed) begin
                     d.write_enable_latch = 1'b0;
                     d.lock_down = 1'b0;
                  end
               end
               default: d.reset_armed = 1'b0;
            endcase
         end
      end

      if (d.cmd_refused) begin
         d.refused_cnt = q.refused_cnt + 8'h1;
      end

      // axi write: address and data taken in either order
      if (s_axi_awvalid && q.awready) begin
         d.aw_got = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_got = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_got && q.w_got && !q.bvalid) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = `SFWP_RESP_OKAY;
         case (decode(q.aw_addr))
            SFWP_SEL_CONTROL: begin
               if (q.w_strb[0] && q.w_data[0]) begin
                  d.lock_down = 1'b1;
               end
            end
            SFWP_SEL_NONE: d.bresp = `SFWP_RESP_SLVERR;
            default: d.bresp = `SFWP_RESP_OKAY;
         endcase
      end
      d.awready = !d.aw_got && !d.bvalid;
      d.wready = !d.w_got && !d.bvalid;

      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rresp = `SFWP_RESP_OKAY;
         case (decode(s_axi_araddr))
            SFWP_SEL_STATUS: d.rdata = {26'h0, q.lock_down,
               q.power == SFWP_PWR_READY, q.power == SFWP_PWR_LOCKED,
               q.deep_power_down, q.write_enable_latch, q.busy};
            SFWP_SEL_CONTROL: d.rdata = {31'h0, q.lock_down};
            SFWP_SEL_CONFIG: d.rdata = {8'h0, q.status_reg_three,
               q.status_reg_two, q.status_reg_one[7:2],
               q.write_enable_latch, q.busy};
            SFWP_SEL_REFUSED: d.rdata = {24'h0, q.refused_cnt};
            default: begin
               d.rdata = 32'h0;
               d.rresp = `SFWP_RESP_SLVERR;
            end
         endcase
      end
      d.arready = !d.rvalid;

      // supply loss: volatile state cleared, configuration kept
      if (!s_supply) begin
         d.power = SFWP_PWR_OFF;
         d.write_enable_latch = 1'b0;
         d.deep_power_down = 1'b0;
         d.busy = 1'b0;
         d.reset_armed = 1'b0;
         d.lock_down = 1'b0;
         d.bit_cnt = 3'h0;
         d.byte_cnt = 3'h0;
      end

      d.hold_func_en = !q.status_reg_two[`SFWP_S2_QUAD] &&
         !q.status_reg_three[`SFWP_S3_PIN_SELECT];
      d.reset_func_en = !q.status_reg_two[`SFWP_S2_QUAD] &&
         q.status_reg_three[`SFWP_S3_PIN_SELECT];
      d.io3_data_mode = q.status_reg_two[`SFWP_S2_QUAD];
      case (q.status_reg_three[`SFWP_S3_DRIVE_HI:`SFWP_S3_DRIVE_LO])
         2'h0: d.drive_pct = `SFWP_DRIVE_PCT_00;
         2'h1: d.drive_pct = `SFWP_DRIVE_PCT_01;
         2'h2: d.drive_pct = `SFWP_DRIVE_PCT_10;
         default: d.drive_pct = `SFWP_DRIVE_PCT_11;
      endcase
      d.quad_hf_mode = q.status_reg_three[`SFWP_S3_HIGH_FREQ];
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         q <= '0;
         q.status_reg_one <= `SFWP_S1_RESET;
         q.status_reg_two <= `SFWP_S2_RESET;
         q.status_reg_three <= `SFWP_S3_RESET;
         q.sclk_prev <= 1'b0;
         q.cs_prev <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign hold_func_en = q.hold_func_en;
   assign reset_func_en = q.reset_func_en;
   assign io3_data_mode = q.io3_data_mode;
   assign drive_pct = q.drive_pct;
   assign quad_hf_mode = q.quad_hf_mode;
   assign prog_start = q.prog_start;
   assign erase_start = q.erase_start;
   assign status_write = q.status_write;
   assign op_addr = q.op_addr;
   assign cmd_refused = q.cmd_refused;
   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bresp = q.bresp;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_arready = q.arready;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign s_axi_rvalid = q.rvalid;
endmodule
`default_nettype wire

// >>> bench/sfwp_top_sva.sv
/* Assertions on the ports of sfwp_top, bound below.
 Assumes a synchronous active-low reset on sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module sfwp_top_sva (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic supply_good,
   input wire logic hold_func_en,
   input wire logic reset_func_en,
   input wire logic io3_data_mode,
   input wire logic [6:0] drive_pct,
   input wire logic prog_start,
   input wire logic erase_start,
   input wire logic status_write,
   input wire logic [18:0] op_addr,
   input wire logic cmd_refused
);
   wire go = prog_start | erase_start | status_write;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   AST_PIN_SEL: assert property ($past(rst_n, 2) |->
      $onehot({hold_func_en, reset_func_en, io3_data_mode}))
      else $error("pin function not one-hot");
   AST_QUAD: assert property (io3_data_mode |->
      !hold_func_en && !reset_func_en) else $error("pin not data only");
   AST_DRIVE: assert property ($past(rst_n, 2) |->
      drive_pct inside {7'h32, 7'h19, 7'h4b, 7'h64}) else $error("drive");
   AST_PUW: assert property ($rose(supply_good) |=> !go [*8])
      else $error("write started during power-up delay");
   AST_OFF: assert property (!supply_good [*5] |->
      !go && !cmd_refused) else $error("command while supply low");
   AST_PAGE: assert property (prog_start |->
      op_addr[7:0] == 8'h00) else $error("program not page aligned");
   AST_ONE: assert property (cmd_refused |-> !go)
      else $error("refused and started together");
   AST_BUSY: assert property (go |=> !go [*4])
      else $error("start while busy");
endmodule
bind sfwp_top sfwp_top_sva i_sfwp_top_sva (.sys_clk, .rst_n, .supply_good,
   .hold_func_en, .reset_func_en, .io3_data_mode, .drive_pct, .prog_start,
   .erase_start, .status_write, .op_addr, .cmd_refused);
`default_nettype wire

// >>> bench/sfwp_spi_host.sv
/* Link partner: an SPI host sending frames MSB first.
 Assumes the device samples data at link-clock rising edges. */
`timescale 1ns/1ps
`default_nettype none
module sfwp_spi_host (
   output logic sclk,
   output logic cs_n,
   output logic mosi
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // clock stands low between frames; idle data shows the inverse
   task automatic frame(input logic [39:0] b, input int n);
      cs_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         mosi <= b[39 - i];
         #31.25 sclk <= 1'b1;
         #62.5 sclk <= 1'b0;
         #31.25;
      end
      cs_n <= 1'b1;
      mosi <= ~mosi;
      #200;
   endtask
endmodule
`default_nettype wire

// >>> bench/tb_sfwp_top.sv
/* Bench of sfwp_top: frames via the host model, AXI4-Lite here.
 Assumes the bound checker; pulses are checked against a queue. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
error_cnt++; $display("CHECK FAILED t=%0t mismatch", $time); end end
module tb_sfwp_top;
   localparam logic [22:0] P = 23'h400000, E = 23'h200000;
   localparam logic [22:0] S = 23'h100000, R = 23'h080000, N = 23'h0;
   localparam logic [39:0] WRITE_ENABLE_CMD = 40'h0600000000, PROG = 40'h0200010000;
   localparam logic [39:0] WS0 = 40'h0100000000;
   localparam logic [6:0] DP [4] = '{7'h32, 7'h19, 7'h4b, 7'h64};
   // sr1, sr2, sector address, protected
   localparam logic [43:0] TBL [16] = '{44'h240000f0001, 44'h24000100000,
      44'h280001f0001, 44'h2c0003f0001, 44'h2c000400000, 44'h300007f0001,
      44'h64000000001, 44'h64000010000, 44'h6c000030001, 44'h6c000040000,
      44'h70000070001, 44'h70000080000, 44'h04000000000, 44'h18000000001,
      44'h24400000000, 44'h24400100001};
   logic sys_clk, rst_n, supply_good, wp_n, spi_sclk, spi_cs_n, spi_mosi;
   logic hold_func_en, reset_func_en, io3_data_mode, quad_hf_mode;
   logic prog_start, erase_start, status_write, cmd_refused;
   logic [6:0] drive_pct;
   logic [18:0] op_addr;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb;
   logic [2:0] pe;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [22:0] exp_q [$];
   int error_cnt = 0;
   int comparisons = 0;
   wire ev = prog_start | erase_start | status_write | cmd_refused;
   wire [22:0] obs = {prog_start, erase_start, status_write, cmd_refused,
      op_addr & {19{prog_start | erase_start}}};
   sfwp_top #(.PUW_CYCLES(16'h190), .OP_CYCLES(16'h4)) i_sfwp_top (.*);
   sfwp_spi_host i_sfwp_spi_host (.sclk(spi_sclk), .cs_n(spi_cs_n),
      .mosi(spi_mosi));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (rst_n && ev) begin
         `CHK(exp_q.size() > 0, 1'b1)
         `CHK(obs, exp_q.pop_front())
      end
   end
   task automatic op(input logic [39:0] b, input int n, input logic [22:0] e);
      if (e !== N) exp_q.push_back(e);
      i_sfwp_spi_host.frame(b, n);
   endtask
   task automatic wr(input logic [39:0] b, input int n, input logic [22:0] e);
      op(WRITE_ENABLE_CMD, 8, N);
      op(b, n, e);
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            `CHK(s_axi_bresp, er)
            s_axi_bready <= 1'b0;
         end
      end while (s_axi_bready);
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] m,
      input logic [33:0] e);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            `CHK({s_axi_rresp, s_axi_rdata & m}, e)
            s_axi_rready <= 1'b0;
         end
      end while (s_axi_rready);
   endtask
   task automatic tally_and_finish;
      `CHK(exp_q.size(), 0)
      $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      v = $urandom(32'h80fbbdf9);
      {rst_n, supply_good, wp_n, s_axi_wstrb} = 7'h1f;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
      s_axi_wdata = 32'h0;
      rst_n = 1'b0;
      supply_good = 1'b0;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      axr(8'h00, 32'h2, 34'h0);
      supply_good <= 1'b1;
      op(WRITE_ENABLE_CMD, 8, R);
      axr(8'h00, 32'h18, 34'h8);
      repeat (400) @(posedge sys_clk);
      op(PROG, 32, R);
      wr(PROG, 32, P | 23'h100);
      op(PROG, 32, R);
      wr(PROG, 35, R);
      foreach (TBL[i]) begin
         wr({8'h01, TBL[i][43:28], 16'h0}, 24, S);
         wr({8'h20, TBL[i][27:4], 8'h0}, 32, TBL[i][0] ? R :
            E | {4'h0, TBL[i][22:4]});
      end
      for (int k = 0; k < 4; k++) begin
         v = $urandom;
         v[4] = k[0];
         wr({8'h01, 8'h00, 6'h0, v[4], 1'b0, 16'h0}, 24, S);
         wr({8'h11, v[3:0], 28'h0}, 16, S);
         @(negedge sys_clk);
         pe = {~v[4] & ~v[3], ~v[4] & v[3], v[4]};
         `CHK({hold_func_en, reset_func_en}, pe[2:1])
         `CHK(io3_data_mode, pe[0])
         `CHK(drive_pct, DP[v[2:1]])
         `CHK(quad_hf_mode, v[0])
      end
      @(posedge sys_clk) wp_n <= 1'b0;
      wr(40'h0180000000, 24, S);
      wr(WS0, 24, R);
      @(posedge sys_clk) wp_n <= 1'b1;
      wr(WS0, 24, S);
      op(40'hb900000000, 8, N);
      axr(8'h00, 32'h4, 34'h4);
      wr(PROG, 32, N);
      op(40'hab00000000, 8, N);
      wr(PROG, 32, P | 23'h100);
      op(WRITE_ENABLE_CMD, 8, N);
      op(40'h0400000000, 8, N);
      op(PROG, 32, R);
      wr(40'hd802000000, 32, E | 23'h20000);
      wr(40'hc700000000, 8, E);
      wr(40'h3102000000, 16, S);
      axr(8'h08, 32'hff00, 34'h200);
      axw(8'h04, 32'h1, 2'h0);
      wr(WS0, 24, R);
      axr(8'h04, 32'h1, 34'h1);
      op(40'h6600000000, 8, N);
      op(40'h9900000000, 8, N);
      axr(8'h00, 32'h20, 34'h0);
      axw(8'h10, 32'h0, 2'h2);
      axr(8'h10, 32'hffffffff, 34'h200000000);
      op(WRITE_ENABLE_CMD, 8, N);
      axr(8'h00, 32'h2, 34'h2);
      @(posedge sys_clk) supply_good <= 1'b0;
      repeat (10) @(posedge sys_clk);
      op(WRITE_ENABLE_CMD, 8, N);
      @(posedge sys_clk) supply_good <= 1'b1;
      repeat (500) @(posedge sys_clk);
      axr(8'h00, 32'h1a, 34'h10);
      tally_and_finish();
   end
   initial begin
      #380000;
      `CHK(1'b0, 1'b1)
      tally_and_finish();
   end
endmodule
`default_nettype wire
